// [logic/pprneg_pkg.sv]
// package for the ppr transfer agreement block
package pprneg_pkg;
    localparam int          ID_W          = 4;
    localparam int          NUM_PEERS     = 16;
    localparam logic [7:0]  PERIOD_ASYNC  = 8'h00;
    localparam logic [7:0]  OFFSET_ASYNC  = 8'h00;
    localparam logic [7:0]  PERIOD_FAST80 = 8'h09;
    localparam logic [7:0]  WIDTH_NARROW  = 8'h00;
    localparam logic [7:0]  WIDTH_WIDE    = 8'h01;
    localparam logic [7:0]  OPTS_NONE     = 8'h00;
    localparam int          OPT_IU_POS    = 0;
    localparam int          OPT_DT_POS    = 1;
    localparam int          OPT_QAS_POS   = 2;
    localparam logic [7:0]  OPT_LEGAL_MSK = 8'h07;

    typedef struct packed {
        logic [7:0] period;
        logic [7:0] offset;
        logic [7:0] width;
        logic [7:0] opts;
    } pprneg_agree_t;

    typedef enum logic [3:0] {
        PPRNEG_ST     = 4'b0001,
        PPRNEG_DT     = 4'b0010,
        PPRNEG_DT_IU  = 4'b0100,
        PPRNEG_DT_QAS = 4'b1000
    } pprneg_mode_t;

    localparam pprneg_agree_t AGREE_DEFAULT = '{PERIOD_ASYNC, OFFSET_ASYNC, WIDTH_NARROW, OPTS_NONE};
endpackage : pprneg_pkg

// [logic/pprneg_target.sv]
// target-side ppr agreement store, responder and data-phase mode decode
`timescale 1ns/1ps
module pprneg_target (
    // clock and reset
    input  wire logic                      i_sys_clk,
    input  wire logic                      i_reset,
    // capabilities of this target
    input  wire logic [7:0]                i_min_period,
    input  wire logic [7:0]                i_max_offset,
    input  wire logic                      i_wide_ok,
    input  wire logic [7:0]                i_opts_ok,
    // incoming ppr request
    input  wire logic                      i_req_valid,
    input  wire logic [pprneg_pkg::ID_W-1:0] i_req_peer,
    input  wire pprneg_pkg::pprneg_agree_t i_req,
    // reply completion, pins sampled elsewhere
    input  wire logic                      i_reply_done,
    input  wire logic                      i_reply_atn,
    input  wire logic                      i_reply_abort,
    // indeterminate events for a peer or all
    input  wire logic                      i_invalid_one,
    input  wire logic                      i_invalid_all,
    input  wire logic [pprneg_pkg::ID_W-1:0] i_invalid_peer,
    // current connection and phase
    input  wire logic [pprneg_pkg::ID_W-1:0] i_cur_peer,
    input  wire logic                      i_data_phase,
    // reply toward message engine
    output logic                           o_reply_valid,
    output pprneg_pkg::pprneg_agree_t      o_reply,
    output logic                           o_wdtr_req,
    output logic [pprneg_pkg::ID_W-1:0]    o_wdtr_peer,
    output logic                           o_bus_free,
    // applied transfer settings
    output logic                           o_sync,
    output logic [7:0]                     o_period,
    output logic [7:0]                     o_offset,
    output logic                           o_wide,
    output pprneg_pkg::pprneg_mode_t       o_mode
);
    pprneg_pkg::pprneg_agree_t             table_q [pprneg_pkg::NUM_PEERS];
    logic                                  pending;
    logic [pprneg_pkg::ID_W-1:0]           pend_peer;
    pprneg_pkg::pprneg_agree_t             pend_rec;
    pprneg_pkg::pprneg_agree_t             next_reply;
    pprneg_pkg::pprneg_agree_t             cur;
    logic                                  commit;

    // legal set only: none, dt, dt+iu, dt+iu+qas
    function automatic logic [7:0] legalize(input logic [7:0] o);
        logic [7:0] r;
        r = o & pprneg_pkg::OPT_LEGAL_MSK;
        if (!r[pprneg_pkg::OPT_DT_POS]) r = pprneg_pkg::OPTS_NONE;
        else if (!r[pprneg_pkg::OPT_IU_POS]) r[pprneg_pkg::OPT_QAS_POS] = 1'b0;
        return r;
    endfunction : legalize

    // response built from request; never a reject
    always_comb begin
        next_reply        = i_req;
        if (i_req.period < i_min_period)
            next_reply.period = i_min_period;
        if (i_req.offset > i_max_offset)
            next_reply.offset = i_max_offset;
        if (!i_wide_ok)
            next_reply.width = pprneg_pkg::WIDTH_NARROW;
        next_reply.opts   = legalize(i_req.opts & i_opts_ok);
        // options need wide; drop them if narrow
        if (next_reply.width != pprneg_pkg::WIDTH_WIDE)
            next_reply.opts = pprneg_pkg::OPTS_NONE;
        // options zero at fast-80 cannot run; treat as async narrow
        if (next_reply.opts == pprneg_pkg::OPTS_NONE && next_reply.period == pprneg_pkg::PERIOD_FAST80)
            next_reply = pprneg_pkg::AGREE_DEFAULT;
    end

    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reply_valid <= 1'b0;
            o_reply       <= pprneg_pkg::AGREE_DEFAULT;
            pending       <= 1'b0;
            pend_peer     <= '0;
            pend_rec      <= pprneg_pkg::AGREE_DEFAULT;
        end else begin
            o_reply_valid <= i_req_valid;
            if (i_req_valid) begin
                o_reply   <= next_reply;
                pend_rec  <= next_reply;
                pend_peer <= i_req_peer;
                pending   <= 1'b1;
            end else if (i_reply_done || i_reply_abort) begin
                pending   <= 1'b0;
            end
        end
    end

    // only a clean last byte commits; atn or abort leaves async default
    assign commit = pending && i_reply_done && !i_reply_atn && !i_reply_abort;

    // per-peer records kept across selections and role swaps
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < pprneg_pkg::NUM_PEERS; i++)
                table_q[i] <= pprneg_pkg::AGREE_DEFAULT;
        end else begin
            for (int i = 0; i < pprneg_pkg::NUM_PEERS; i++) begin
                if (i_invalid_all || (i_invalid_one && i_invalid_peer == i[pprneg_pkg::ID_W-1:0]))
                    table_q[i] <= pprneg_pkg::AGREE_DEFAULT;
                else if (pending && (i_reply_done || i_reply_abort) && pend_peer == i[pprneg_pkg::ID_W-1:0])
                    table_q[i] <= commit ? pend_rec : pprneg_pkg::AGREE_DEFAULT;
            end
        end
    end

    // indeterminate for one peer (i_invalid_one): start wdtr narrow; iu change: bus free
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_wdtr_req  <= 1'b0;
            o_wdtr_peer <= '0;
            o_bus_free  <= 1'b0;
        end else begin
            o_wdtr_req  <= i_invalid_one;
            o_wdtr_peer <= i_invalid_peer;
            o_bus_free  <= commit &&
                (pend_rec.opts[pprneg_pkg::OPT_IU_POS] != table_q[pend_peer].opts[pprneg_pkg::OPT_IU_POS]);
        end
    end

    assign cur = table_q[i_cur_peer];

    // settings apply in data phases only; otherwise async narrow
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_sync   <= 1'b0;
            o_period <= pprneg_pkg::PERIOD_ASYNC;
            o_offset <= pprneg_pkg::OFFSET_ASYNC;
            o_wide   <= 1'b0;
            o_mode   <= pprneg_pkg::PPRNEG_ST;
        end else begin
            o_sync   <= i_data_phase && cur.offset != pprneg_pkg::OFFSET_ASYNC;
            o_period <= i_data_phase ? cur.period : pprneg_pkg::PERIOD_ASYNC;
            o_offset <= i_data_phase ? cur.offset : pprneg_pkg::OFFSET_ASYNC;
            o_wide   <= i_data_phase && cur.width == pprneg_pkg::WIDTH_WIDE;
            if (!i_data_phase || !cur.opts[pprneg_pkg::OPT_DT_POS])
                o_mode <= pprneg_pkg::PPRNEG_ST;
            else if (!cur.opts[pprneg_pkg::OPT_IU_POS])
                o_mode <= pprneg_pkg::PPRNEG_DT;
            else if (!cur.opts[pprneg_pkg::OPT_QAS_POS])
                o_mode <= pprneg_pkg::PPRNEG_DT_IU;
            else
                o_mode <= pprneg_pkg::PPRNEG_DT_QAS;
        end
    end

    // assertions on the reply
    reply_no_new_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_req_valid
        |=> (o_reply.opts & ~$past(i_req.opts)) == 8'h00)
        else $error("reply enabled an option not requested");
    reply_period_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_req_valid && i_req.period >= i_min_period && i_req.period != pprneg_pkg::PERIOD_FAST80
        |=> o_reply.period == $past(i_req.period))
        else $error("supported period not echoed");
    reply_offset_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_req_valid
        |=> o_reply.offset <= $past(i_max_offset))
        else $error("reply offset above limit");
    reply_legal_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_reply_valid
        |-> o_reply.opts inside {8'h00, 8'h02, 8'h03, 8'h07})
        else $error("illegal option combination");
    reply_valid_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_req_valid
        |=> o_reply_valid)
        else $error("request left without a reply");
    reply_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !i_req_valid
        |=> !o_reply_valid)
        else $error("reply without a request");
    reply_narrow_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_req_valid && !i_wide_ok
        |=> o_reply.width == pprneg_pkg::WIDTH_NARROW)
        else $error("wide reply from a narrow target");
    reply_minper_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_req_valid
        |=> o_reply.period >= $past(i_min_period) || o_reply == pprneg_pkg::AGREE_DEFAULT)
        else $error("reply period below target limit");
    reply_offset_echo_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_req_valid && i_req.offset <= i_max_offset
        |=> o_reply.offset == $past(i_req.offset) || o_reply == pprneg_pkg::AGREE_DEFAULT)
        else $error("acceptable offset not echoed");
    reply_opts_ok_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_req_valid
        |=> (o_reply.opts & ~$past(i_opts_ok)) == 8'h00)
        else $error("reply enabled an unsupported option");
    reply_wide_opts_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_reply_valid && o_reply.width != pprneg_pkg::WIDTH_WIDE
        |-> o_reply.opts == pprneg_pkg::OPTS_NONE)
        else $error("options on a narrow reply");
    reply_keep_opts_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_req_valid && (i_req.opts & i_opts_ok & pprneg_pkg::OPT_LEGAL_MSK) == 8'h07 && i_wide_ok && i_req.width == 8'h01
        |=> o_reply.opts == 8'h07)
        else $error("supported options dropped");
    reply_fast80_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_reply_valid && o_reply.opts == pprneg_pkg::OPTS_NONE
        |-> o_reply.period != pprneg_pkg::PERIOD_FAST80)
        else $error("fast-80 period without options");

    // assertions on the agreement store
    invalid_async_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_invalid_all ##1 i_data_phase
        |=> !o_sync && !o_wide && o_mode == pprneg_pkg::PPRNEG_ST)
        else $error("indeterminate agreement still in use");
    invalid_one_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_invalid_one
        |=> table_q[$past(i_invalid_peer)] == pprneg_pkg::AGREE_DEFAULT)
        else $error("indeterminate peer record kept");
    atn_no_commit_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        pending && i_reply_done && i_reply_atn && !i_invalid_all
        |=> table_q[$past(pend_peer)] == pprneg_pkg::AGREE_DEFAULT)
        else $error("agreement kept despite attention");
    commit_store_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        commit && !i_invalid_all && !(i_invalid_one && i_invalid_peer == pend_peer)
        |=> table_q[$past(pend_peer)] == $past(pend_rec))
        else $error("clean reply not stored");
    abort_default_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        pending && i_reply_abort
        |=> table_q[$past(pend_peer)] == pprneg_pkg::AGREE_DEFAULT)
        else $error("failed negotiation left an agreement");
    peer_apart_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        commit && i_cur_peer != pend_peer && !i_invalid_all && !i_invalid_one
        |=> table_q[$past(i_cur_peer)] == $past(cur))
        else $error("commit disturbed another peer");

    // assertions on the applied settings
    nondata_async_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !i_data_phase
        |=> !o_sync && !o_wide && o_offset == 8'h00)
        else $error("non-data phase not async narrow");
    nondata_mode_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !i_data_phase
        |=> o_mode == pprneg_pkg::PPRNEG_ST && o_period == pprneg_pkg::PERIOD_ASYNC)
        else $error("non-data phase uses agreed mode");
    data_sync_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_data_phase
        |=> o_sync == ($past(cur.offset) != pprneg_pkg::OFFSET_ASYNC))
        else $error("sync flag disagrees with offset");
    data_limits_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_data_phase
        |=> o_period == $past(cur.period) && o_offset == $past(cur.offset))
        else $error("applied limits differ from agreement");
    data_wide_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_data_phase
        |=> o_wide == ($past(cur.width) == pprneg_pkg::WIDTH_WIDE))
        else $error("applied width differs from agreement");
    mode_dt_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_data_phase && cur.opts[pprneg_pkg::OPT_DT_POS]
        |=> o_mode != pprneg_pkg::PPRNEG_ST)
        else $error("dt agreement applied as st");
    mode_qas_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_data_phase && cur.opts == 8'h07
        |=> o_mode == pprneg_pkg::PPRNEG_DT_QAS)
        else $error("qas agreement not applied");
    mode_onehot_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        1'b1
        |-> $onehot(o_mode))
        else $error("mode not one-hot");

    // assertions on the wdtr and bus free pulses
    wdtr_start_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_invalid_one
        |=> o_wdtr_req && o_wdtr_peer == $past(i_invalid_peer))
        else $error("no wdtr after indeterminate agreement");
    wdtr_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        !i_invalid_one
        |=> !o_wdtr_req)
        else $error("wdtr without indeterminate agreement");
    iu_busfree_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_bus_free
        |-> $past(commit))
        else $error("bus free without a committed iu change");
    busfree_iu_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        commit && pend_rec.opts[pprneg_pkg::OPT_IU_POS] != table_q[pend_peer].opts[pprneg_pkg::OPT_IU_POS]
        |=> o_bus_free)
        else $error("iu change committed without bus free");
endmodule : pprneg_target

// [verif/pprneg_init_model.sv]
// initiator partner model: issues ppr requests and closes them
`timescale 1ns/1ps
module pprneg_init_model (
    // clock
    input  wire logic                      i_sys_clk,
    // target answers
    input  wire logic                      i_reply_valid,
    input  wire pprneg_pkg::pprneg_agree_t i_reply,
    input  wire logic                      i_bus_free,
    // toward the target
    output logic                           o_req_valid,
    output logic [3:0]                     o_req_peer,
    output pprneg_pkg::pprneg_agree_t      o_req,
    output logic                           o_done,
    output logic                           o_atn,
    output logic                           o_abort
);
    initial begin
        {o_req_valid, o_req_peer, o_req, o_done, o_atn, o_abort} = '0;
    end
    // fate 0 clean, 1 attention on last byte, 2 abort
    task automatic negotiate(input logic [3:0] p, input pprneg_pkg::pprneg_agree_t q, input int fate,
                             input int gap, output logic seen, output pprneg_pkg::pprneg_agree_t rep,
                             output logic bf);
        {o_req_valid, o_req_peer, o_req} = {1'b1, p, q};
        @(posedge i_sys_clk);
        #1;
        seen = i_reply_valid;
        rep = i_reply;
        // released fields must not keep the request
        {o_req_valid, o_req_peer, o_req} = {1'b0, ~p, ~q};
        // completion keeps the same offset after an edge, even with no gap
        repeat (gap) begin
            @(posedge i_sys_clk);
            #1;
        end
        o_done = (fate != 2);
        o_atn = (fate == 1);
        o_abort = (fate == 2);
        @(posedge i_sys_clk);
        #1;
        bf = i_bus_free;
        {o_done, o_atn, o_abort} = '0;
    endtask : negotiate
endmodule : pprneg_init_model

// [verif/tb_top.sv]
// self-checking bench for the target ppr agreement block
`timescale 1ns/1ps
module tb_top;
    logic                      clk, rst, wok, inv1, inva, dph, rv, dn, atn, ab, rpv, wq, bfr, snc, wd, seen, bf;
    logic [7:0]                minp, maxo, ook, per, ofs;
    logic [3:0]                ivp, cp, wp, rp, pk;
    pprneg_pkg::pprneg_agree_t rq, rpl, q, got, e, rec [16];
    pprneg_pkg::pprneg_mode_t  md;
    int                        failures, samples_checked, cycles;
    logic [31:0]               sd;
    pprneg_target dut_u (.i_sys_clk(clk), .i_reset(rst), .i_min_period(minp), .i_max_offset(maxo),
        .i_wide_ok(wok), .i_opts_ok(ook), .i_req_valid(rv), .i_req_peer(rp), .i_req(rq), .i_reply_done(dn),
        .i_reply_atn(atn), .i_reply_abort(ab), .i_invalid_one(inv1), .i_invalid_all(inva),
        .i_invalid_peer(ivp), .i_cur_peer(cp), .i_data_phase(dph), .o_reply_valid(rpv), .o_reply(rpl),
        .o_wdtr_req(wq), .o_wdtr_peer(wp), .o_bus_free(bfr), .o_sync(snc), .o_period(per), .o_offset(ofs),
        .o_wide(wd), .o_mode(md));
    pprneg_init_model model_u (.i_sys_clk(clk), .i_reply_valid(rpv), .i_reply(rpl), .i_bus_free(bfr),
        .o_req_valid(rv), .o_req_peer(rp), .o_req(rq), .o_done(dn), .o_atn(atn), .o_abort(ab));
    function automatic logic [31:0] xs();
        sd = sd ^ (sd << 13);
        sd = sd ^ (sd >> 17);
        sd = sd ^ (sd << 5);
        return sd;
    endfunction : xs
    function automatic pprneg_pkg::pprneg_agree_t exp_reply(pprneg_pkg::pprneg_agree_t a);
        pprneg_pkg::pprneg_agree_t r;
        r.period = (a.period < minp) ? minp : a.period;
        r.offset = (a.offset > maxo) ? maxo : a.offset;
        r.width = {7'h00, wok & a.width[0]};
        r.opts = a.opts & ook & 8'h07;
        if (!r.opts[1] || r.width == 8'h00) r.opts = 8'h00;
        else if (!r.opts[0]) r.opts = 8'h02;
        if (r.opts == 8'h00 && r.period == 8'h09) r = pprneg_pkg::AGREE_DEFAULT;
        return r;
    endfunction : exp_reply
    function automatic pprneg_pkg::pprneg_mode_t exp_mode(logic [7:0] o);
        if (!o[1]) return pprneg_pkg::PPRNEG_ST;
        if (!o[0]) return pprneg_pkg::PPRNEG_DT;
        return o[2] ? pprneg_pkg::PPRNEG_DT_QAS : pprneg_pkg::PPRNEG_DT_IU;
    endfunction : exp_mode
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask : check
    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic settings(input logic [3:0] p);
        {cp, dph} = {p, 1'b1};
        repeat (2) @(posedge clk);
        #1;
        check("sync", snc, rec[p].offset != 8'h00);
        if (rec[p].offset != 8'h00) check("period offset", {per, ofs}, {rec[p].period, rec[p].offset});
        check("wide", wd, rec[p].width == 8'h01);
        check("mode", md, exp_mode(rec[p].opts));
        dph = 1'b0;
        @(posedge clk);
        #1;
        check("outside data", {snc, wd, per, ofs, md}, {2'b00, 16'h0000, pprneg_pkg::PPRNEG_ST});
    endtask : settings
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard: a full run needs about 300 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        {rst, wok, inv1, inva, dph, minp, maxo, ook, ivp, cp} = {1'b1, 36'h0};
        sd = 32'd5367;
        foreach (rec[i]) rec[i] = pprneg_pkg::AGREE_DEFAULT;
        repeat (20) @(posedge clk);
        #1;
        rst = 1'b0;
        check("reset state", {rpv, wq, bfr, md}, {3'b000, pprneg_pkg::PPRNEG_ST});
        for (int n = 0; n < 40; n++) begin
            pk = 4'(xs());
            // first requests meet the lowest target period so fast-80 without options is reached
            minp = n < 4 ? 8'h08 : 8'(xs() % 64) | 8'h08;
            maxo = 8'(xs());
            wok = n < 6 || xs() % 2 != 0;
            ook = n < 8 ? 8'hff : 8'(xs());
            q.period = (n % 5 == 0) ? 8'h09 : 8'(xs() % 64) | 8'h08;
            q.offset = 8'(xs());
            q.width = n == 0 ? 8'h00 : 8'(xs() % 2);
            q.opts = n < 4 ? 8'h07 : 8'(xs());
            model_u.negotiate(pk, q, n % 7 == 3 ? 1 : n % 7 == 5 ? 2 : 0, xs() % 3, seen, got, bf);
            e = exp_reply(q);
            check("reply valid", seen, 1'b1);
            check("reply", got, e);
            if (n % 7 == 3 || n % 7 == 5) rec[pk] = pprneg_pkg::AGREE_DEFAULT;
            else begin
                check("bus free", bf, e.opts[0] != rec[pk].opts[0]);
                rec[pk] = e;
            end
            settings(pk);
        end
        {ivp, inv1} = {pk, 1'b1};
        @(posedge clk);
        #1;
        inv1 = 1'b0;
        check("wdtr", {wq, wp}, {1'b1, pk});
        rec[pk] = pprneg_pkg::AGREE_DEFAULT;
        settings(pk);
        inva = 1'b1;
        @(posedge clk);
        #1;
        inva = 1'b0;
        foreach (rec[i]) rec[i] = pprneg_pkg::AGREE_DEFAULT;
        for (int i = 0; i < 16; i++) settings(i[3:0]);
        report_and_stop();
    end
endmodule : tb_top
